//--- core/cdbu_core.sv
// What this block does
// [RULE1] Snapshot status, PC, SP on debugger entry
// [RULE2] Status snapshot keeps documented per-thread flag bits
// [RULE3] Fetch operands: 8-bit thread, 5-bit index
// [RULE4] Write 3-bit cause code per interrupt
// [RULE5] Record raising thread; zero for host
// [RULE6] Record lowest firing unit; zero otherwise
// [RULE7] Store address or resource id as data
// [RULE8] Stop mask holds threads after debug return
// [RULE9] Eight scratch words shared by both spaces
// [RULE10] Four instruction breakpoints compare PC
// [RULE11] Breakpoint bit0 enable, bit1 not-equal select
// [RULE12] Per-thread enable field gates every unit
// [RULE13] Four data watchpoints with two addresses
// [RULE14] Watch control: enable, AND/OR, loads too
// [RULE15] Resource watch: mask, value, A/B select
// [RULE16] Protect bit makes config path read-only
// [RULE17] Identification word: processor, node, revision, version
// [RULE18] Capacity words report resource counts
// [RULE19] Software forms status resource identifier
// [RULE20] Config message tokens and answer tokens
// [RULE21] Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none

module cdbu_core #(
	parameter logic [7:0] PROC_ID       = 8'h00, // Arbitrary value
	parameter logic [7:0] NODE_NUM      = 8'h00,
	parameter logic [7:0] REVISION      = 8'h01, // Arbitrary value
	parameter logic [7:0] VERSION       = 8'h01, // Arbitrary value
	parameter logic [7:0] NUM_CHANENDS  = 8'h20,
	parameter logic [7:0] NUM_LOCKS     = 8'h04,
	parameter logic [7:0] NUM_SYNCS     = 8'h07,
	parameter logic [7:0] NUM_CLKBLKS   = 8'h06,
	parameter logic [7:0] NUM_TIMERS    = 8'h0a
) (
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	input  wire cdbu_pkg::cdbu_req_type    ps_req,
	output logic [31:0]                    ps_rdata,
	input  wire cdbu_pkg::cdbu_req_type    cfg_req,
	output logic [31:0]                    cfg_rdata,
	output logic                           cfg_ok,
	input  wire logic                      host_request,
	input  wire logic                      debug_call,
	input  wire logic [7:0]                cur_thread,
	input  wire logic                      instr_valid,
	input  wire cdbu_pkg::cdbu_snap_type   snap,
	input  wire cdbu_pkg::cdbu_access_type access,
	input  wire logic                      debug_mode,
	output logic                           debug_entry,
	output logic [7:0]                     thread_stop,
	output logic [7:0]                     fetch_thread,
	output logic [4:0]                     fetch_index
);

	localparam int NU = 4;

	// Register storage
	logic [31:0] status_reg;
	logic [31:0] pc_reg;
	logic [31:0] sp_reg;
	logic [7:0]  fthread_reg;
	logic [4:0]  findex_reg;
	logic [2:0]  cause_reg;
	logic [7:0]  cthread_reg;
	logic [1:0]  cunit_reg;
	logic [31:0] edata_reg;
	logic [7:0]  stop_reg;
	logic [31:0] scratch_reg [8];
	logic [31:0] ibrk_addr_reg [NU];
	logic [31:0] ibrk_ctrl_reg [NU];
	logic [31:0] dwch_a_reg [NU];
	logic [31:0] dwch_b_reg [NU];
	logic [31:0] dwch_ctrl_reg [NU];
	logic [31:0] rwch_mask_reg [NU];
	logic [31:0] rwch_val_reg [NU];
	logic [31:0] rwch_ctrl_reg [NU];
	logic        protect_reg;

	logic [NU-1:0] ibrk_hit;
	logic [NU-1:0] dwch_hit;
	logic [NU-1:0] rwch_hit;
	logic          any_hit;
	logic          entry;
	logic [2:0]    cause_next;
	logic [1:0]    unit_next;
	logic [31:0]   edata_next;

	wire ps_wr  = ps_req.valid & ps_req.write;
	wire cfg_wr = cfg_req.valid & cfg_req.write & ~protect_reg; // [RULE16]

	// Per-unit comparators
	genvar g;
	generate
		for (g = 0; g < NU; g++)
		begin : g_unit
			wire thr_ok_i = ibrk_ctrl_reg[g][cdbu_pkg::CTRL_THR_LSB + cur_thread[2:0]]; // [RULE12]
			wire pc_eq    = (snap.pc == ibrk_addr_reg[g]);
			wire cond_i   = ibrk_ctrl_reg[g][cdbu_pkg::CTRL_SEL_BIT] ? ~pc_eq : pc_eq; // [RULE11]
			assign ibrk_hit[g] = instr_valid & ibrk_ctrl_reg[g][cdbu_pkg::CTRL_EN_BIT]
				& thr_ok_i & cond_i & (cur_thread[7:3] == 5'h00); // [RULE10]

			// Condition A: at or above first address; B: at or below second
			wire cond_a  = (access.mem_addr >= dwch_a_reg[g]);
			wire cond_b  = (access.mem_addr <= dwch_b_reg[g]);
			wire comb_d  = dwch_ctrl_reg[g][cdbu_pkg::CTRL_SEL_BIT] ? (cond_a | cond_b)
				: (cond_a & cond_b); // [RULE14]
			wire kind_ok = ~access.mem_load | dwch_ctrl_reg[g][cdbu_pkg::CTRL_LOAD_BIT];
			wire thr_d   = dwch_ctrl_reg[g][cdbu_pkg::CTRL_THR_LSB + cur_thread[2:0]]; // [RULE12]
			assign dwch_hit[g] = access.mem_valid & dwch_ctrl_reg[g][cdbu_pkg::CTRL_EN_BIT]
				& thr_d & kind_ok & comb_d & (cur_thread[7:3] == 5'h00); // [RULE13]

			// Condition A: masked match; B: masked mismatch
			wire res_eq = ((access.res_id & rwch_mask_reg[g])
				== (rwch_val_reg[g] & rwch_mask_reg[g]));
			wire cond_r = rwch_ctrl_reg[g][cdbu_pkg::CTRL_SEL_BIT] ? ~res_eq : res_eq;
			wire thr_r  = rwch_ctrl_reg[g][cdbu_pkg::CTRL_THR_LSB + cur_thread[2:0]]; // [RULE12]
			assign rwch_hit[g] = access.res_valid & rwch_ctrl_reg[g][cdbu_pkg::CTRL_EN_BIT]
				& thr_r & cond_r & (cur_thread[7:3] == 5'h00); // [RULE15]
		end
	endgenerate

	// Lowest firing unit of a group
	function automatic logic [1:0] cdbu_lowest(input logic [NU-1:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int i = NU - 1; i >= 0; i--)
			if (v[i])
				r = 2'(i);
		return r;
	endfunction : cdbu_lowest

	// Cause priority: host, call, instruction, data, resource
	always_comb
	begin
		cause_next = cdbu_pkg::CAUSE_HOST;
		unit_next  = 2'h0;
		edata_next = edata_reg;
		if (host_request)
			cause_next = cdbu_pkg::CAUSE_HOST; // [RULE4]
		else if (debug_call)
			cause_next = cdbu_pkg::CAUSE_CALL; // [RULE4]
		else if (|ibrk_hit)
		begin
			cause_next = cdbu_pkg::CAUSE_IBRK;
			unit_next  = cdbu_lowest(ibrk_hit); // [RULE6]
		end
		else if (|dwch_hit)
		begin
			cause_next = cdbu_pkg::CAUSE_DWCH;
			unit_next  = cdbu_lowest(dwch_hit); // [RULE6]
			edata_next = access.mem_addr; // [RULE7]
		end
		else if (|rwch_hit)
		begin
			cause_next = cdbu_pkg::CAUSE_RWCH;
			unit_next  = cdbu_lowest(rwch_hit); // [RULE6]
			edata_next = access.res_id; // [RULE7]
		end
	end

	// No new entry while already in debug mode
	assign any_hit = host_request | debug_call | (|ibrk_hit) | (|dwch_hit) | (|rwch_hit);
	assign entry   = any_hit & ~debug_mode;

	// Entry pulse to the pipeline
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			debug_entry <= 1'b0;
		else
			debug_entry <= entry;
	end

	// Snapshot registers; entry wins over a same-cycle write
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			status_reg <= cdbu_pkg::RESET_WORD;
			pc_reg     <= cdbu_pkg::RESET_WORD;
			sp_reg     <= cdbu_pkg::RESET_WORD;
		end
		else if (entry)
		begin
			status_reg <= snap.status & cdbu_pkg::STATUS_MASK; // [RULE1] [RULE2]
			pc_reg     <= snap.pc; // [RULE1]
			sp_reg     <= snap.sp; // [RULE1]
		end
		else if (ps_wr)
		begin
			if (ps_req.index == cdbu_pkg::PS_SAVED_STATUS)
				status_reg <= ps_req.wdata & cdbu_pkg::STATUS_MASK; // [RULE21]
			if (ps_req.index == cdbu_pkg::PS_SAVED_PC)
				pc_reg <= ps_req.wdata;
			if (ps_req.index == cdbu_pkg::PS_SAVED_SP)
				sp_reg <= ps_req.wdata;
		end
	end

	// Cause record; entry wins over a same-cycle write
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cause_reg   <= 3'h0;
			cthread_reg <= 8'h00;
			cunit_reg   <= 2'h0;
			edata_reg   <= cdbu_pkg::RESET_WORD;
		end
		else if (entry)
		begin
			cause_reg   <= cause_next; // [RULE4]
			cthread_reg <= host_request ? 8'h00 : cur_thread; // [RULE5]
			cunit_reg   <= unit_next; // [RULE6]
			edata_reg   <= edata_next; // [RULE7]
		end
		else if (ps_wr)
		begin
			if (ps_req.index == cdbu_pkg::PS_CAUSE)
			begin
				cause_reg   <= ps_req.wdata[2:0];
				cthread_reg <= ps_req.wdata[15:8];
				cunit_reg   <= ps_req.wdata[17:16];
			end
			if (ps_req.index == cdbu_pkg::PS_EVENT_DATA)
				edata_reg <= ps_req.wdata;
		end
	end

	// Fetch operands and stop mask
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			fthread_reg <= 8'h00;
			findex_reg  <= 5'h00;
			stop_reg    <= 8'h00;
		end
		else if (ps_wr)
		begin
			if (ps_req.index == cdbu_pkg::PS_FETCH_THREAD)
				fthread_reg <= ps_req.wdata[7:0]; // [RULE3]
			if (ps_req.index == cdbu_pkg::PS_FETCH_INDEX)
				findex_reg <= ps_req.wdata[4:0]; // [RULE3]
			if (ps_req.index == cdbu_pkg::PS_STOP_MASK)
				stop_reg <= ps_req.wdata[7:0]; // [RULE8]
		end
	end

	// Stopped threads only held outside debug mode
	assign thread_stop  = debug_mode ? 8'h00 : stop_reg; // [RULE8]
	assign fetch_thread = fthread_reg;
	assign fetch_index  = findex_reg;

	// Scratch words: one store, two access paths; status path wins a tie
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			for (int i = 0; i < 8; i++)
				scratch_reg[i] <= cdbu_pkg::RESET_WORD;
		else
			for (int i = 0; i < 8; i++)
				if (ps_wr && ps_req.index == cdbu_pkg::PS_SCRATCH_BASE + 8'(i))
					scratch_reg[i] <= ps_req.wdata; // [RULE9]
				else if (cfg_wr && cfg_req.index == cdbu_pkg::CF_SCRATCH_BASE + 8'(i))
					scratch_reg[i] <= cfg_req.wdata; // [RULE9] [RULE16]
	end

	// Break and watch unit registers
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			for (int i = 0; i < NU; i++)
			begin
				ibrk_addr_reg[i] <= cdbu_pkg::RESET_WORD;
				ibrk_ctrl_reg[i] <= cdbu_pkg::RESET_WORD;
				dwch_a_reg[i]    <= cdbu_pkg::RESET_WORD;
				dwch_b_reg[i]    <= cdbu_pkg::RESET_WORD;
				dwch_ctrl_reg[i] <= cdbu_pkg::RESET_WORD;
				rwch_mask_reg[i] <= cdbu_pkg::RESET_WORD;
				rwch_val_reg[i]  <= cdbu_pkg::RESET_WORD;
				rwch_ctrl_reg[i] <= cdbu_pkg::RESET_WORD;
			end
		else if (ps_wr)
			for (int i = 0; i < NU; i++)
			begin
				if (ps_req.index == cdbu_pkg::PS_IBRK_ADDR_BASE + 8'(i))
					ibrk_addr_reg[i] <= ps_req.wdata; // [RULE10]
				if (ps_req.index == cdbu_pkg::PS_IBRK_CTRL_BASE + 8'(i))
					ibrk_ctrl_reg[i] <= ps_req.wdata & cdbu_pkg::IBRK_CTRL_MASK; // [RULE21]
				if (ps_req.index == cdbu_pkg::PS_DWCH_A_BASE + 8'(i))
					dwch_a_reg[i] <= ps_req.wdata; // [RULE13]
				if (ps_req.index == cdbu_pkg::PS_DWCH_B_BASE + 8'(i))
					dwch_b_reg[i] <= ps_req.wdata; // [RULE13]
				if (ps_req.index == cdbu_pkg::PS_DWCH_CTRL_BASE + 8'(i))
					dwch_ctrl_reg[i] <= ps_req.wdata & cdbu_pkg::DWCH_CTRL_MASK; // [RULE21]
				if (ps_req.index == cdbu_pkg::PS_RWCH_MASK_BASE + 8'(i))
					rwch_mask_reg[i] <= ps_req.wdata; // [RULE15]
				if (ps_req.index == cdbu_pkg::PS_RWCH_VAL_BASE + 8'(i))
					rwch_val_reg[i] <= ps_req.wdata; // [RULE15]
				if (ps_req.index == cdbu_pkg::PS_RWCH_CTRL_BASE + 8'(i))
					rwch_ctrl_reg[i] <= ps_req.wdata & cdbu_pkg::RWCH_CTRL_MASK; // [RULE21]
			end
	end

	// Protect bit; writable while clear, frozen once set until reset
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			protect_reg <= 1'b0;
		else if (cfg_wr && cfg_req.index == cdbu_pkg::CF_PROTECT)
			protect_reg <= cfg_req.wdata[cdbu_pkg::PROTECT_BIT]; // [RULE16]
	end

	// Status space read mux; unmapped words read zero
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ps_rdata <= cdbu_pkg::RESET_WORD;
		else
		begin
			ps_rdata <= 32'h0000_0000; // [RULE21]
			unique case (ps_req.index)
				cdbu_pkg::PS_SAVED_STATUS: ps_rdata <= status_reg; // [RULE2]
				cdbu_pkg::PS_SAVED_PC:     ps_rdata <= pc_reg;
				cdbu_pkg::PS_SAVED_SP:     ps_rdata <= sp_reg;
				cdbu_pkg::PS_FETCH_THREAD: ps_rdata <= {24'h00_0000, fthread_reg};
				cdbu_pkg::PS_FETCH_INDEX:  ps_rdata <= {27'h000_0000, findex_reg};
				cdbu_pkg::PS_CAUSE:
					ps_rdata <= {14'h0000, cunit_reg, cthread_reg, 5'h00, cause_reg};
				cdbu_pkg::PS_EVENT_DATA:   ps_rdata <= edata_reg;
				cdbu_pkg::PS_STOP_MASK:    ps_rdata <= {24'h00_0000, stop_reg};
				default:
					for (int i = 0; i < 8; i++)
					begin
						if (ps_req.index == cdbu_pkg::PS_SCRATCH_BASE + 8'(i))
							ps_rdata <= scratch_reg[i];
						if (i < NU)
						begin
							if (ps_req.index == cdbu_pkg::PS_IBRK_ADDR_BASE + 8'(i))
								ps_rdata <= ibrk_addr_reg[i];
							if (ps_req.index == cdbu_pkg::PS_IBRK_CTRL_BASE + 8'(i))
								ps_rdata <= ibrk_ctrl_reg[i];
							if (ps_req.index == cdbu_pkg::PS_DWCH_A_BASE + 8'(i))
								ps_rdata <= dwch_a_reg[i];
							if (ps_req.index == cdbu_pkg::PS_DWCH_B_BASE + 8'(i))
								ps_rdata <= dwch_b_reg[i];
							if (ps_req.index == cdbu_pkg::PS_DWCH_CTRL_BASE + 8'(i))
								ps_rdata <= dwch_ctrl_reg[i];
							if (ps_req.index == cdbu_pkg::PS_RWCH_MASK_BASE + 8'(i))
								ps_rdata <= rwch_mask_reg[i];
							if (ps_req.index == cdbu_pkg::PS_RWCH_VAL_BASE + 8'(i))
								ps_rdata <= rwch_val_reg[i];
							if (ps_req.index == cdbu_pkg::PS_RWCH_CTRL_BASE + 8'(i))
								ps_rdata <= rwch_ctrl_reg[i];
						end
					end
			endcase
		end
	end

	// Config space read mux and success flag
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cfg_rdata <= cdbu_pkg::RESET_WORD;
			cfg_ok    <= 1'b0;
		end
		else
		begin
			cfg_rdata <= 32'h0000_0000;
			// Writes refused while protected report failure
			cfg_ok    <= ~(cfg_req.valid & cfg_req.write & protect_reg); // [RULE20]
			unique case (cfg_req.index)
				cdbu_pkg::CF_IDENT:
					cfg_rdata <= {PROC_ID, NODE_NUM, REVISION, VERSION}; // [RULE17]
				cdbu_pkg::CF_CAPACITY_ONE:
					cfg_rdata <= {NUM_CHANENDS, NUM_LOCKS, NUM_SYNCS, 8'h00}; // [RULE18]
				cdbu_pkg::CF_CAPACITY_TWO:
					cfg_rdata <= {16'h0000, NUM_CLKBLKS, NUM_TIMERS}; // [RULE18]
				cdbu_pkg::CF_PROTECT:
					cfg_rdata <= {protect_reg, 31'h0000_0000};
				default:
					for (int i = 0; i < 8; i++)
						if (cfg_req.index == cdbu_pkg::CF_SCRATCH_BASE + 8'(i))
							cfg_rdata <= scratch_reg[i]; // [RULE9]
			endcase
		end
	end

endmodule : cdbu_core

`default_nettype wire

//--- core/cdbu_pkg.sv
package cdbu_pkg;

	// Processor status space word indices
	localparam logic [7:0] PS_SAVED_STATUS   = 8'h10;
	localparam logic [7:0] PS_SAVED_PC       = 8'h11;
	localparam logic [7:0] PS_SAVED_SP       = 8'h12;
	localparam logic [7:0] PS_FETCH_THREAD   = 8'h13;
	localparam logic [7:0] PS_FETCH_INDEX    = 8'h14;
	localparam logic [7:0] PS_CAUSE          = 8'h15;
	localparam logic [7:0] PS_EVENT_DATA     = 8'h16;
	localparam logic [7:0] PS_STOP_MASK      = 8'h18;
	localparam logic [7:0] PS_SCRATCH_BASE   = 8'h20;
	localparam logic [7:0] PS_IBRK_ADDR_BASE = 8'h30;
	localparam logic [7:0] PS_IBRK_CTRL_BASE = 8'h40;
	localparam logic [7:0] PS_DWCH_A_BASE    = 8'h50;
	localparam logic [7:0] PS_DWCH_B_BASE    = 8'h60;
	localparam logic [7:0] PS_DWCH_CTRL_BASE = 8'h70;
	localparam logic [7:0] PS_RWCH_MASK_BASE = 8'h80;
	localparam logic [7:0] PS_RWCH_VAL_BASE  = 8'h90;
	localparam logic [7:0] PS_RWCH_CTRL_BASE = 8'h9c;

	// Tile configuration space word indices
	localparam logic [7:0] CF_IDENT          = 8'h00;
	localparam logic [7:0] CF_CAPACITY_ONE   = 8'h01;
	localparam logic [7:0] CF_CAPACITY_TWO   = 8'h02;
	localparam logic [7:0] CF_PROTECT        = 8'h04;
	localparam logic [7:0] CF_SCRATCH_BASE   = 8'h20;

	// Field positions
	localparam int         PROTECT_BIT       = 31;
	localparam int         CTRL_EN_BIT       = 0;
	localparam int         CTRL_SEL_BIT      = 1;
	localparam int         CTRL_LOAD_BIT     = 2;
	localparam int         CTRL_THR_LSB      = 16;
	localparam logic [31:0] STATUS_MASK      = 32'h0000_00df;
	localparam logic [31:0] IBRK_CTRL_MASK   = 32'h00ff_0003;
	localparam logic [31:0] DWCH_CTRL_MASK   = 32'h00ff_0007;
	localparam logic [31:0] RWCH_CTRL_MASK   = 32'h00ff_0003;

	// Cause codes
	localparam logic [2:0] CAUSE_HOST        = 3'h1;
	localparam logic [2:0] CAUSE_CALL        = 3'h2;
	localparam logic [2:0] CAUSE_IBRK        = 3'h3;
	localparam logic [2:0] CAUSE_DWCH        = 3'h4;
	localparam logic [2:0] CAUSE_RWCH        = 3'h5;

	// Reset values
	localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

	// Configuration message tokens
	localparam logic [7:0] TOK_WRITE         = 8'hc0;
	localparam logic [7:0] TOK_READ          = 8'hc1;
	localparam logic [7:0] TOK_ACK           = 8'h03;
	localparam logic [7:0] TOK_NACK          = 8'h04;
	localparam logic [7:0] TOK_END           = 8'h01;

	// Register access request
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  index;
		logic [31:0] wdata;
	} cdbu_req_type;

	// Thread state snapshot presented by the pipeline
	typedef struct packed {
		logic [31:0] status;
		logic [31:0] pc;
		logic [31:0] sp;
	} cdbu_snap_type;

	// Memory and resource activity for watch units
	typedef struct packed {
		logic        mem_valid;
		logic        mem_load;
		logic [31:0] mem_addr;
		logic        res_valid;
		logic [31:0] res_id;
	} cdbu_access_type;

endpackage : cdbu_pkg

//--- testbench/cdbu_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cdbu_core_sva #(
	parameter logic [7:0] PROC_ID  = 8'h00,
	parameter logic [7:0] NODE_NUM = 8'h00,
	parameter logic [7:0] REVISION = 8'h00,
	parameter logic [7:0] VERSION  = 8'h00
) (
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire cdbu_pkg::cdbu_req_type ps_req,
	input wire logic [31:0]            ps_rdata,
	input wire cdbu_pkg::cdbu_req_type cfg_req,
	input wire logic [31:0]            cfg_rdata,
	input wire logic                   cfg_ok,
	input wire logic                   host_request,
	input wire logic                   debug_call,
	input wire logic                   debug_mode,
	input wire logic                   debug_entry,
	input wire logic [7:0]             thread_stop,
	input wire logic [7:0]             fetch_thread,
	input wire logic [4:0]             fetch_index
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic ps_wr;
	logic cf_wr;
	logic prot_reg;
	// Write strobes of both access paths
	assign ps_wr = ps_req.valid && ps_req.write;
	assign cf_wr = cfg_req.valid && cfg_req.write;
	// Mirror of the protect bit; once set it sticks until reset
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			prot_reg <= 1'b0;
		else if (cf_wr && cfg_req.index == cdbu_pkg::CF_PROTECT)
			prot_reg <= prot_reg | cfg_req.wdata[31];
	end
	a_host_entry: assert property (host_request && !debug_mode |=> debug_entry)
		else $error("host request gave no entry pulse");
	a_call_entry: assert property (debug_call && !debug_mode |=> debug_entry)
		else $error("debug call gave no entry pulse");
	a_host_cause: assert property (host_request && !debug_mode ##1 debug_mode && !ps_wr
		&& ps_req.index == cdbu_pkg::PS_CAUSE |=> ps_rdata == 32'h0000_0001)
		else $error("host cause word wrong");
	a_stop_release: assert property (debug_mode |-> thread_stop == 8'h00)
		else $error("threads held while in debug mode");
	a_stop_hold: assert property (!debug_mode && !$past(debug_mode) && !$past(ps_wr)
		&& !$past(sys_rst) |-> $stable(thread_stop))
		else $error("stop mask moved without a write");
	a_fetch_thread: assert property (ps_wr && ps_req.index == cdbu_pkg::PS_FETCH_THREAD
		|=> {24'h0000_00, fetch_thread} == ($past(ps_req.wdata) & 32'h0000_00ff))
		else $error("thread operand not taken");
	a_fetch_index: assert property (ps_wr && ps_req.index == cdbu_pkg::PS_FETCH_INDEX
		|=> {27'h000_0000, fetch_index} == ($past(ps_req.wdata) & 32'h0000_001f))
		else $error("index operand not taken");
	a_reserved_zero: assert property (ps_req.index == cdbu_pkg::PS_FETCH_INDEX
		|=> ps_rdata[31:5] == '0)
		else $error("reserved bits read nonzero");
	a_scratch_shared: assert property (ps_wr && ps_req.index == 8'h20 ##1 !ps_wr && !cf_wr
		##1 !ps_wr && !cf_wr && cfg_req.index == 8'h20 |=> cfg_rdata == $past(ps_req.wdata, 3))
		else $error("scratch word differs between spaces");
	a_protect_refuse: assert property (prot_reg && cf_wr |=> !cfg_ok)
		else $error("protected write acknowledged");
	a_write_accept: assert property (!prot_reg && cf_wr |=> cfg_ok)
		else $error("open write refused");
	a_ident_word: assert property (cfg_req.index == cdbu_pkg::CF_IDENT
		|=> cfg_rdata == {PROC_ID, NODE_NUM, REVISION, VERSION})
		else $error("identification word wrong");
endmodule : cdbu_core_sva
bind cdbu_core cdbu_core_sva #(
	.PROC_ID  (PROC_ID),
	.NODE_NUM (NODE_NUM),
	.REVISION (REVISION),
	.VERSION  (VERSION)
) u_sva (
	.clk_sys      (clk_sys),
	.sys_rst      (sys_rst),
	.ps_req       (ps_req),
	.ps_rdata     (ps_rdata),
	.cfg_req      (cfg_req),
	.cfg_rdata    (cfg_rdata),
	.cfg_ok       (cfg_ok),
	.host_request (host_request),
	.debug_call   (debug_call),
	.debug_mode   (debug_mode),
	.debug_entry  (debug_entry),
	.thread_stop  (thread_stop),
	.fetch_thread (fetch_thread),
	.fetch_index  (fetch_index)
);
`default_nettype wire

//--- testbench/cdbu_debugger.sv
`timescale 1ns/1ps
`default_nettype none
module cdbu_debugger (
	input  wire logic                  clk_sys,
	output var cdbu_pkg::cdbu_req_type cfg_req,
	input  wire logic [31:0]           cfg_rdata,
	input  wire logic                  cfg_ok
);
	initial cfg_req = '0; // Idle until the first message
	// One message, answer token from the ack bit; an idle edge keeps calls apart
	task automatic msg(input logic [7:0] tok, input logic [7:0] idx, input logic [31:0] wd,
		output logic [7:0] ans, output logic [31:0] rd);
		cfg_req = {1'b1, tok == cdbu_pkg::TOK_WRITE, idx, wd};
		@(posedge clk_sys);
		#1;
		cfg_req.valid = 1'b0;
		ans = cfg_ok ? cdbu_pkg::TOK_ACK : cdbu_pkg::TOK_NACK;
		rd = cfg_rdata;
		@(posedge clk_sys) #1;
	endtask : msg
endmodule : cdbu_debugger
`default_nettype wire

//--- testbench/cdbu_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("Error %s expected %h seen %h", nm, exp, got); \
		end \
	end
module cdbu_core_bench;
	logic                      clk_sys = 1'b0;
	logic                      sys_rst = 1'b1;
	cdbu_pkg::cdbu_req_type    ps_req = '0;
	cdbu_pkg::cdbu_req_type    cfg_req;
	logic [31:0]               ps_rdata, cfg_rdata, r;
	logic                      cfg_ok, debug_entry;
	logic                      host_request = 1'b0, debug_call = 1'b0;
	logic                      instr_valid = 1'b0, debug_mode = 1'b0;
	logic [7:0]                cur_thread = 8'h00, thread_stop, fetch_thread, tk;
	logic [4:0]                fetch_index;
	cdbu_pkg::cdbu_snap_type   snap = '0;
	cdbu_pkg::cdbu_access_type access = '0;
	int                        error_cnt = 0, compares = 0;
	logic [7:0]  idx_tab [10] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h15, 8'h18, 8'h80, 8'h40, 8'h70,
		8'h9c};
	logic [31:0] msk_tab [10] = '{32'h0000_00df, 32'hffff_ffff, 32'h0000_00ff, 32'h0000_001f,
		32'h0003_ff07, 32'h0000_00ff, 32'hffff_ffff, 32'h00ff_0003, 32'h00ff_0007, 32'h00ff_0003};
	// Identification values are arbitrary
	cdbu_core #(.PROC_ID(8'h5a), .NODE_NUM(8'h02), .REVISION(8'h03), .VERSION(8'h04)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ps_req(ps_req),
		.ps_rdata(ps_rdata), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ok(cfg_ok),
		.host_request(host_request), .debug_call(debug_call), .cur_thread(cur_thread),
		.instr_valid(instr_valid), .snap(snap), .access(access), .debug_mode(debug_mode),
		.debug_entry(debug_entry), .thread_stop(thread_stop), .fetch_thread(fetch_thread),
		.fetch_index(fetch_index));
	cdbu_debugger u_dbg (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
		.cfg_ok(cfg_ok));
	// Free-running core clock
	always #5 clk_sys = ~clk_sys;
	// Status-space access; an idle edge keeps valid from toggling twice in a step
	task automatic ps(input logic w, input logic [7:0] i, input logic [31:0] d);
		ps_req = {1'b1, w, i, d};
		@(posedge clk_sys);
		#1;
		ps_req.valid = 1'b0;
		r = ps_rdata;
		@(posedge clk_sys) #1;
	endtask : ps
	task automatic cf(input logic w, input logic [7:0] i, input logic [31:0] d);
		u_dbg.msg(w ? cdbu_pkg::TOK_WRITE : cdbu_pkg::TOK_READ, i, d, tk, r);
	endtask : cf
	// Fire staged activity for one cycle, then inspect the captured cause
	task automatic fire(input logic hit, input logic [31:0] cause, input logic [31:0] data);
		@(posedge clk_sys);
		#1;
		{host_request, debug_call, instr_valid, access.mem_valid, access.res_valid} = '0;
		`CHK("entry", hit, debug_entry)
		if (hit)
		begin
			debug_mode = 1'b1;
			ps(1'b0, cdbu_pkg::PS_CAUSE, 32'h0000_0000);
			`CHK("cause", cause, r)
			ps(1'b0, cdbu_pkg::PS_EVENT_DATA, 32'h0000_0000);
			if (cause[2:0] > 3'h3)
				`CHK("event data", data, r)
			debug_mode = 1'b0;
		end
	endtask : fire
	task automatic dw(input logic [31:0] c, input logic ld, input logic [31:0] a, input logic h);
		ps(1'b1, 8'h72, c);
		access.mem_load = ld;
		access.mem_addr = a;
		access.mem_valid = 1'b1;
		fire(h, 32'h0002_0004, a);
	endtask : dw
	task automatic rw(input logic [31:0] c, input logic [31:0] id, input logic h);
		ps(1'b1, 8'h9d, c);
		access.res_id = id;
		access.res_valid = 1'b1;
		fire(h, 32'h0001_0005, id);
	endtask : rw
	task automatic stop_test;
		$display("Comparisons %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// Watchdog far beyond the expected run of a few hundred cycles
	initial
	begin
		#50_000;
		error_cnt++;
		$display("Error watchdog expired");
		stop_test();
	end
	initial
	begin
		repeat (8) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		for (int k = 0; k < 10; k++)
		begin
			ps(1'b0, idx_tab[k], 32'h0000_0000);
			`CHK("reset value", 32'h0000_0000, r)
			ps(1'b1, idx_tab[k], 32'hffff_ffff);
			ps(1'b0, idx_tab[k], 32'h0000_0000);
			`CHK("field mask", msk_tab[k], r)
		end
		`CHK("stop mask", 8'hff, thread_stop)
		`CHK("fetch operands", 13'h1fff, {fetch_thread, fetch_index})
		debug_mode = 1'b1;
		#1;
		`CHK("stop released", 8'h00, thread_stop)
		debug_mode = 1'b0;
		for (int k = 5; k < 10; k++)
			ps(1'b1, idx_tab[k], 32'h0000_0000);
		cf(1'b1, cdbu_pkg::CF_IDENT, 32'hffff_ffff);
		cf(1'b0, cdbu_pkg::CF_IDENT, 32'h0000_0000);
		`CHK("ident", 32'h5a02_0304, r)
		cf(1'b0, cdbu_pkg::CF_CAPACITY_ONE, 32'h0000_0000);
		`CHK("capacity one", 32'h2004_0700, r)
		cf(1'b0, cdbu_pkg::CF_CAPACITY_TWO, 32'h0000_0000);
		`CHK("capacity two", 32'h0000_060a, r)
		ps(1'b1, 8'h20, 32'h1234_5678);
		cf(1'b0, 8'h20, 32'h0000_0000);
		`CHK("scratch via config", 32'h1234_5678, r)
		cf(1'b1, 8'h27, 32'hcafe_0001);
		ps(1'b0, 8'h27, 32'h0000_0000);
		`CHK("scratch via status", 32'hcafe_0001, r)
		// Host entry captures the running thread state
		cur_thread = 8'h05;
		snap = {32'hffff_ffff, 32'h0000_4000, 32'h0001_fff0};
		host_request = 1'b1;
		fire(1'b1, 32'h0000_0001, 32'h0000_0000);
		ps(1'b0, cdbu_pkg::PS_SAVED_STATUS, 32'h0000_0000);
		`CHK("saved status", 32'h0000_00df, r)
		ps(1'b0, cdbu_pkg::PS_SAVED_PC, 32'h0000_0000);
		`CHK("saved pc", 32'h0000_4000, r)
		ps(1'b0, cdbu_pkg::PS_SAVED_SP, 32'h0000_0000);
		`CHK("saved sp", 32'h0001_fff0, r)
		debug_mode = 1'b1;
		host_request = 1'b1;
		fire(1'b0, 32'h0000_0000, 32'h0000_0000);
		debug_mode = 1'b0;
		cur_thread = 8'h03;
		debug_call = 1'b1;
		fire(1'b1, 32'h0000_0302, 32'h0000_0000);
		// Two breakpoints on one address: lowest unit wins
		ps(1'b1, 8'h31, 32'h0000_0800);
		ps(1'b1, 8'h32, 32'h0000_0800);
		ps(1'b1, 8'h41, 32'h0010_0001);
		ps(1'b1, 8'h42, 32'h0010_0001);
		snap.pc = 32'h0000_0800;
		instr_valid = 1'b1;
		fire(1'b0, 32'h0000_0000, 32'h0000_0000);
		cur_thread = 8'h04;
		instr_valid = 1'b1;
		fire(1'b1, 32'h0001_0403, 32'h0000_0000);
		ps(1'b1, 8'h42, 32'h0000_0000);
		ps(1'b1, 8'h41, 32'h0010_0003);
		instr_valid = 1'b1;
		fire(1'b0, 32'h0000_0000, 32'h0000_0000);
		snap.pc = 32'h0000_0804;
		instr_valid = 1'b1;
		fire(1'b1, 32'h0001_0403, 32'h0000_0000);
		ps(1'b1, 8'h41, 32'h0000_0000);
		cur_thread = 8'h00;
		ps(1'b1, 8'h52, 32'h0000_1000);
		ps(1'b1, 8'h62, 32'h0000_1fff);
		dw(32'h0001_0001, 1'b0, 32'h0000_1800, 1'b1);
		dw(32'h0001_0001, 1'b1, 32'h0000_1800, 1'b0);
		dw(32'h0001_0005, 1'b1, 32'h0000_1800, 1'b1);
		dw(32'h0001_0005, 1'b0, 32'h0000_2000, 1'b0);
		dw(32'h0001_0003, 1'b0, 32'h0000_2000, 1'b1);
		dw(32'h0002_0003, 1'b0, 32'h0000_2000, 1'b0);
		ps(1'b1, 8'h72, 32'h0000_0000);
		ps(1'b1, 8'h81, 32'hffff_ff00);
		ps(1'b1, 8'h91, 32'h0000_1200);
		rw(32'h0001_0001, 32'h0000_1234, 1'b1);
		rw(32'h0001_0003, 32'h0000_1234, 1'b0);
		rw(32'h0001_0003, 32'h0000_5634, 1'b1);
		rw(32'h0001_0000, 32'h0000_5634, 1'b0);
		// Protect turns the configuration path read-only
		cf(1'b1, cdbu_pkg::CF_PROTECT, 32'hffff_ffff);
		`CHK("protect ack", cdbu_pkg::TOK_ACK, tk)
		cf(1'b0, cdbu_pkg::CF_PROTECT, 32'h0000_0000);
		`CHK("protect bit", 32'h8000_0000, r)
		cf(1'b1, 8'h20, 32'h0bad_0bad);
		`CHK("protected nack", cdbu_pkg::TOK_NACK, tk)
		cf(1'b0, 8'h20, 32'h0000_0000);
		`CHK("protected scratch", 32'h1234_5678, r)
		`CHK("read ack", cdbu_pkg::TOK_ACK, tk)
		ps(1'b1, 8'h20, 32'h0000_0055);
		cf(1'b0, 8'h20, 32'h0000_0000);
		`CHK("status path open", 32'h0000_0055, r)
		stop_test();
	end
endmodule : cdbu_core_bench
`default_nettype wire
